/* File: hw/aosd_pkg.sv */
// Package with constants and carrier types of the analog output scaling and diagnostic block.
package aosd_pkg;

  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned REC_BYTES      = 20;

  // Time base of the microsecond ticker.
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_NS        = 1000;
  localparam int unsigned TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Output function codes.
  localparam logic [7:0] FN_OFF          = 8'hFF;
  localparam logic [7:0] FN_0_20_LONG    = 8'h31;
  localparam logic [7:0] FN_0_20_SHORT   = 8'h41;
  localparam logic [7:0] FN_4_20_LONG    = 8'h30;
  localparam logic [7:0] FN_4_20_SHORT   = 8'h40;
  localparam logic [7:0] FN_RESET        = 8'h31;

  // Code limits and slopes; current = (code - floor) * K >> SLOPE_SHIFT in microamps.
  localparam int signed  TOP_LONG        = 32511;
  localparam int signed  TOP_SHORT       = 20480;
  localparam int signed  LIVE_ZERO_LONG  = -6912;
  localparam int signed  LIVE_ZERO_SHORT = -4096;
  localparam int unsigned SLOPE_SHIFT    = 20;
  localparam logic [20:0] K_0_20_LONG    = 21'h0B92F7;
  localparam logic [20:0] K_0_20_SHORT   = 21'h138800;
  localparam logic [20:0] K_4_20_LONG    = 21'h09425F;
  localparam logic [20:0] K_4_20_SHORT   = 21'h0FA000;

  // Parameter record byte positions.
  localparam logic [2:0] PAR_RESERVED    = 3'h0;
  localparam logic [2:0] PAR_OC_MASK     = 3'h1;
  localparam logic [2:0] PAR_FN_BASE     = 3'h2;

  // Diagnostic record byte positions.
  localparam logic [4:0] REC_ERR_SUMMARY = 5'h00;
  localparam logic [4:0] REC_MODULE_INFO = 5'h01;
  localparam logic [4:0] REC_INT_DIAG    = 5'h03;
  localparam logic [4:0] REC_CH_KIND     = 5'h04;
  localparam logic [4:0] REC_DIAG_BITS   = 5'h05;
  localparam logic [4:0] REC_CH_COUNT    = 5'h06;
  localparam logic [4:0] REC_GROUP_ERR   = 5'h07;
  localparam logic [4:0] REC_CH_ERR_BASE = 5'h08;
  localparam logic [4:0] REC_TICK_BASE   = 5'h10;

  // Constant record contents and field positions.
  localparam logic [7:0] MODULE_INFO_VAL = 8'h15;
  localparam logic [7:0] CH_KIND_VAL     = 8'h73;
  localparam logic [7:0] DIAG_BITS_VAL   = 8'h08;
  localparam logic [7:0] CH_COUNT_VAL    = 8'h04;
  localparam int unsigned CHE_PARAM_BIT  = 0;
  localparam int unsigned CHE_OPEN_BIT   = 4;
  localparam int unsigned SUM_FAIL_BIT   = 0;
  localparam int unsigned SUM_INT_BIT    = 1;
  localparam int unsigned SUM_EXT_BIT    = 2;
  localparam int unsigned SUM_CH_BIT     = 3;
  localparam int unsigned SUM_AUX_BIT    = 4;
  localparam int unsigned SUM_PARAM_BIT  = 7;
  localparam int unsigned INT_OVF_BIT    = 3;
  localparam int unsigned INT_COMM_BIT   = 4;

  typedef struct packed {
    logic       wr;
    logic [2:0] index;
    logic [7:0] data;
  } aosd_param_wr_type;

  typedef struct packed {
    logic [NUM_CH-1:0]      enable;
    logic [NUM_CH-1:0][15:0] setpoint_ua;
  } aosd_drive_type;

endpackage

/* File: hw/aosd_core.sv */
// Analog output scaling and read-only diagnostic record of a four channel current output module.
//
// Notes on behaviour
// RQ1: Function code FFh deactivates the channel; no conversion is driven.
// RQ2: Code 31h: 0..27648 maps 0..20 mA, overrange to 32511, negatives give 0 mA.
// RQ3: Code 41h: 0..16384 maps 0..20 mA, overrange to 20480, negatives give 0 mA.
// RQ4: Codes 30h/40h: 0 gives 4 mA, nominal gives 20 mA, floor -6912/-4096 gives 0.
// RQ5: Any error lights the channel indicator and is entered in the record; the code lights channel_led only for parameter and open circuit errors.
// RQ6: No interrupt exists; diagnostics are only read out.
// RQ7: Channel error bit 4 flags open circuit when detection is enabled for it.
// RQ8: Channel error bit 0 flags bad parameters; other channel bits read zero.
// RQ9: Summary byte: failure, internal, external, channel, aux supply, parameter bits.
// RQ10: Internal byte bit 3 buffer overflow, bit 4 communication error.
// RQ11: Module info byte reads class 0101b with channel information bit set.
// RQ12: Channel kind byte reads 73h, analog output.
// RQ13: Diagnostic bits per channel reads 08h.
// RQ14: Channel count reads 04h.
// RQ15: Group error bit n set while channel n has any error.
// RQ16: Free 32-bit microsecond ticker starts at zero and wraps.
// RQ17: Recording a diagnostic event captures the ticker into the snapshot.
// RQ18: Host reads the full record as set 01h or first four bytes as 00h.
// RQ19: CANopen host reads the record at index 2F01h or first bytes at 2F00h.
// RQ20: EtherCAT host reads record bytes at index 5005h, one subindex each.
// RQ21: Host enables open circuit detection per channel, bit n for channel n.
// RQ22: Every function code is 31h after reset until rewritten.
// RQ23: Reserved bits and bytes, channels four to seven included, read zero.
// RQ24: Unknown function code flags parameter errors and keeps the channel off.
`timescale 1ns/1ns
`default_nettype none

module aosd_core
  import aosd_pkg::*;
(
  input  wire logic                        clk,                // Module clock, 10 MHz.
  input  wire logic                        reset,              // Asynchronous reset, active high.
  input  wire logic [NUM_CH-1:0][15:0]     output_code,        // Signed output codes from the bus.
  input  wire aosd_pkg::aosd_param_wr_type param_wr,           // Parameter record byte write.
  input  wire logic                        rec_rd,             // Diagnostic record byte read strobe.
  input  wire logic [4:0]                  rec_index,          // Diagnostic record byte index.
  input  wire logic [NUM_CH-1:0]           open_circuit_pin,   // Open circuit sense from the output stage.
  input  wire logic                        aux_missing_pin,    // Auxiliary supply missing sense.
  input  wire logic                        diag_overflow,      // Internal diagnostic buffer overflow.
  input  wire logic                        comm_error,         // Internal communication error.
  input  wire logic                        module_fault,       // Module failure from self test.
  output aosd_pkg::aosd_drive_type         drive,              // Per channel enable and setpoint.
  output logic [7:0]                       rec_data,           // Record byte, valid with rec_valid.
  output logic                             rec_valid,          // Pulse one cycle after rec_rd.
  output logic [NUM_CH-1:0]                channel_led,        // Channel error indicators.
  output logic                             group_led           // Module error indicator.
);

  typedef struct packed {
    logic [NUM_CH-1:0][7:0]  fn_code;
    logic [NUM_CH-1:0]       oc_mask;
    logic [NUM_CH:0]         sync1;
    logic [NUM_CH:0]         sync2;
    logic [NUM_CH:0]         sync3;
    logic [NUM_CH:0]         sensed;
    logic [3:0]              prescale;
    logic [31:0]             ticker;
    logic [31:0]             snapshot;
    logic [7:0]              err_summary;
    logic [7:0]              int_diag;
    logic [NUM_CH-1:0][7:0]  ch_err;
    aosd_drive_type          drive;
    logic [7:0]              rec_data;
    logic                    rec_valid;
    logic [NUM_CH-1:0]       channel_led;
    logic                    group_led;
  } aosd_state_type;

  aosd_state_type state_q;
  aosd_state_type state_d;

  // Elaboration-time check: the record layout and the sense vectors serve four channels only.
  if (NUM_CH != 4) begin : g_bad_ch
    $error("aosd_core serves exactly four channels");
  end

  // Scales one signed code to microamps, or returns zero with valid low for an unknown code.
  function automatic logic [16:0] aosd_scale(input logic [7:0] fn, input logic [15:0] code);
    logic signed [17:0] d;
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    logic [20:0]        k;
    logic               ok;
    logic [16:0]        rel;
    logic [37:0]        prod;
    d    = 18'(signed'(code));
    lo   = 18'sd0;
    hi   = 18'(TOP_LONG);
    k    = K_0_20_LONG;
    ok   = 1'b1;
    rel  = 17'h00000;
    prod = 38'h0000000000;
    case (fn)
      FN_0_20_LONG: begin
        hi = 18'(TOP_LONG);                                                 // [RQ2]
        k  = K_0_20_LONG;
      end
      FN_0_20_SHORT: begin
        hi = 18'(TOP_SHORT);                                                // [RQ3]
        k  = K_0_20_SHORT;
      end
      FN_4_20_LONG: begin
        lo = 18'(LIVE_ZERO_LONG);                                           // [RQ4]
        k  = K_4_20_LONG;
      end
      FN_4_20_SHORT: begin
        lo = 18'(LIVE_ZERO_SHORT);                                          // [RQ4]
        hi = 18'(TOP_SHORT);
        k  = K_4_20_SHORT;
      end
      default: begin
        ok = 1'b0;                                                          // [RQ24]
      end
    endcase
    // Codes beyond the ends are clamped so the output never leaves the documented span.
    if (d < lo) begin
      d = lo;                                                               // [RQ2] [RQ3] [RQ4]
    end else if (d > hi) begin
      d = hi;
    end
    rel  = 17'(d - lo);
    prod = 38'(rel) * 38'(k);
    // The reciprocal slope is rounded; the error stays under one microamp across the span.
    if (ok) begin
      return {1'b1, prod[SLOPE_SHIFT +: 16]};
    end
    return 17'h00000;
  endfunction

  logic [NUM_CH-1:0][16:0] scaled;
  logic [NUM_CH-1:0]       fn_off;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    assign scaled[ch] = aosd_scale(state_q.fn_code[ch], output_code[ch]);
    assign fn_off[ch] = (state_q.fn_code[ch] == FN_OFF);
  end

  always_comb begin
    logic [NUM_CH-1:0] param_bad;
    logic [NUM_CH-1:0] open_err;
    logic [NUM_CH-1:0] ch_any;
    logic [7:0]        group;
    logic [7:0]        rec_byte;
    logic              new_event;
    param_bad = '0;
    open_err  = '0;
    ch_any    = '0;
    group     = 8'h00;
    rec_byte  = 8'h00;
    new_event = 1'b0;
    state_d   = state_q;

    // Parameter writes; the reserved byte and unused positions are ignored.
    if (param_wr.wr) begin
      if (param_wr.index == PAR_OC_MASK) begin
        state_d.oc_mask = param_wr.data[NUM_CH-1:0];                        // [RQ21]
      end else if (param_wr.index >= PAR_FN_BASE && param_wr.index < PAR_FN_BASE + 3'(NUM_CH)) begin
        state_d.fn_code[2'(param_wr.index - PAR_FN_BASE)] = param_wr.data;
      end
    end

    // External senses pass three flops; a change is taken once the last two agree.
    state_d.sync1 = {aux_missing_pin, open_circuit_pin};
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    for (int i = 0; i <= NUM_CH; i++) begin
      if (state_q.sync2[i] == state_q.sync3[i]) begin
        state_d.sensed[i] = state_q.sync3[i];
      end
    end

    // Microsecond ticker, free running from reset and wrapping naturally.
    if (state_q.prescale == 4'(TICK_CYCLES - 1)) begin
      state_d.prescale = 4'h0;
      state_d.ticker   = state_q.ticker + 32'h00000001;                     // [RQ16]
    end else begin
      state_d.prescale = state_q.prescale + 4'h1;
    end

    // Output drive follows the function code; off and unknown codes drive nothing.
    for (int i = 0; i < NUM_CH; i++) begin
      param_bad[i] = !fn_off[i] && !scaled[i][16];                          // [RQ24]
      state_d.drive.enable[i]      = scaled[i][16];                         // [RQ1]
      state_d.drive.setpoint_ua[i] = scaled[i][15:0];
      // An open output is only reported on an active channel that has detection switched on.
      open_err[i] = state_q.sensed[i] && state_q.oc_mask[i] && scaled[i][16];  // [RQ7]
      state_d.ch_err[i] = 8'h00;                                            // [RQ8] [RQ23]
      state_d.ch_err[i][CHE_PARAM_BIT] = param_bad[i];                      // [RQ8]
      state_d.ch_err[i][CHE_OPEN_BIT]  = open_err[i];                       // [RQ7]
      ch_any[i] = param_bad[i] || open_err[i];
    end

    state_d.int_diag = 8'h00;                                               // [RQ23]
    state_d.int_diag[INT_OVF_BIT]  = diag_overflow;                         // [RQ10]
    state_d.int_diag[INT_COMM_BIT] = comm_error;                            // [RQ10]

    state_d.err_summary = 8'h00;                                            // [RQ23]
    state_d.err_summary[SUM_INT_BIT]   = diag_overflow || comm_error;       // [RQ9]
    state_d.err_summary[SUM_EXT_BIT]   = (|open_err) || state_q.sensed[NUM_CH];
    state_d.err_summary[SUM_CH_BIT]    = |ch_any;
    state_d.err_summary[SUM_AUX_BIT]   = state_q.sensed[NUM_CH];
    state_d.err_summary[SUM_PARAM_BIT] = |param_bad;
    state_d.err_summary[SUM_FAIL_BIT]  = module_fault;

    // Any error bit that newly rises is a recorded event and stamps the ticker.
    new_event = |(state_d.err_summary & ~state_q.err_summary) ||
                |(state_d.int_diag & ~state_q.int_diag);
    for (int i = 0; i < NUM_CH; i++) begin
      new_event = new_event || |(state_d.ch_err[i] & ~state_q.ch_err[i]);
    end
    if (new_event) begin
      state_d.snapshot = state_q.ticker;                                    // [RQ17]
    end

    // Indicators only; there is deliberately no interrupt path out of this block.
    state_d.channel_led = ch_any;                                           // [RQ5] [RQ6]
    state_d.group_led   = |state_d.err_summary || |state_d.int_diag;        // [RQ5]

    group = 8'h00;
    group[NUM_CH-1:0] = {state_q.ch_err[3][CHE_PARAM_BIT] | state_q.ch_err[3][CHE_OPEN_BIT],
                         state_q.ch_err[2][CHE_PARAM_BIT] | state_q.ch_err[2][CHE_OPEN_BIT],
                         state_q.ch_err[1][CHE_PARAM_BIT] | state_q.ch_err[1][CHE_OPEN_BIT],
                         state_q.ch_err[0][CHE_PARAM_BIT] | state_q.ch_err[0][CHE_OPEN_BIT]};  // [RQ15]

    // Record read-out; the reserved byte, channels four to seven and indices past the end read zero.
    if (rec_index == REC_ERR_SUMMARY) begin
      rec_byte = state_q.err_summary;                                       // [RQ9]
    end else if (rec_index == REC_MODULE_INFO) begin
      rec_byte = MODULE_INFO_VAL;                                           // [RQ11]
    end else if (rec_index == REC_INT_DIAG) begin
      rec_byte = state_q.int_diag;                                          // [RQ10]
    end else if (rec_index == REC_CH_KIND) begin
      rec_byte = CH_KIND_VAL;                                               // [RQ12]
    end else if (rec_index == REC_DIAG_BITS) begin
      rec_byte = DIAG_BITS_VAL;                                             // [RQ13]
    end else if (rec_index == REC_CH_COUNT) begin
      rec_byte = CH_COUNT_VAL;                                              // [RQ14]
    end else if (rec_index == REC_GROUP_ERR) begin
      rec_byte = group;                                                     // [RQ15]
    end else if (rec_index >= REC_CH_ERR_BASE && rec_index < REC_CH_ERR_BASE + 5'(NUM_CH)) begin
      rec_byte = state_q.ch_err[2'(rec_index - REC_CH_ERR_BASE)];           // [RQ5]
    end else if (rec_index >= REC_TICK_BASE && rec_index < 5'(REC_BYTES)) begin
      rec_byte = state_q.snapshot[8 * 32'(2'(rec_index - REC_TICK_BASE)) +: 8];  // [RQ17]
    end else begin
      rec_byte = 8'h00;                                                     // [RQ23]
    end
    state_d.rec_valid = rec_rd;
    if (rec_rd) begin
      state_d.rec_data = rec_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q          <= '0;
      state_q.fn_code  <= {NUM_CH{FN_RESET}};                               // [RQ22]
    end else begin
      state_q <= state_d;
    end
  end

  assign drive       = state_q.drive;
  assign rec_data    = state_q.rec_data;
  assign rec_valid   = state_q.rec_valid;
  assign channel_led = state_q.channel_led;
  assign group_led   = state_q.group_led;

endmodule // aosd_core

`default_nettype wire

/* File: verif/aosd_core_properties.sv */
// Concurrent checks on the ports of the scaling and diagnostic block.
`timescale 1ns/1ns
`default_nettype none

module aosd_core_properties
  import aosd_pkg::*;
(
  input wire logic                    clk,              // Module clock.
  input wire logic                    reset,            // Asynchronous reset.
  input wire logic [NUM_CH-1:0][15:0] output_code,      // Output codes.
  input wire aosd_param_wr_type       param_wr,         // Parameter write.
  input wire logic                    rec_rd,           // Record read strobe.
  input wire logic [4:0]              rec_index,        // Record byte index.
  input wire logic [NUM_CH-1:0]       open_circuit_pin, // Open sense.
  input wire logic                    aux_missing_pin,  // Aux sense.
  input wire logic                    diag_overflow,    // Overflow.
  input wire logic                    comm_error,       // Comm error.
  input wire logic                    module_fault,     // Module failure.
  input wire aosd_drive_type          drive,            // Drive outputs.
  input wire logic [7:0]              rec_data,         // Record byte.
  input wire logic                    rec_valid,        // Read answer.
  input wire logic [NUM_CH-1:0]       channel_led,      // Channel indicators.
  input wire logic                    group_led         // Module indicator.
);
  import aosd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_read_answered: assert property (rec_rd |=> rec_valid) else $error("read not answered");
  a_data_stands: assert property (!rec_rd |=> !rec_valid && $stable(rec_data)) else $error("byte moved");
  a_info_byte: assert property (rec_rd && rec_index == 5'h01 |=> rec_data == 8'h15) else $error("info");
  a_kind_byte: assert property (rec_rd && rec_index == 5'h04 |=> rec_data == 8'h73) else $error("kind");
  a_bits_byte: assert property (rec_rd && rec_index == 5'h05 |=> rec_data == 8'h08) else $error("bits");
  a_count_byte: assert property (rec_rd && rec_index == 5'h06 |=> rec_data == 8'h04) else $error("count");
  a_reserved_zero: assert property (rec_rd && (rec_index == 5'h02 || rec_index inside {[5'h0C:5'h0F]}
    || rec_index >= 5'h14) |=> rec_data == 8'h00) else $error("reserved byte set");
  a_int_reserved: assert property (rec_rd && rec_index == 5'h03 |=> (rec_data & 8'hE7) == 8'h00)
    else $error("internal reserved bit");
  a_group_reserved: assert property (rec_rd && rec_index == 5'h07 |=> rec_data[7:4] == 4'h0)
    else $error("group reserved bit");
  a_off_no_current: assert property (!drive.enable[0] |-> drive.setpoint_ua[0] == 16'h0000)
    else $error("current while off");
  a_fault_lights: assert property ($rose(module_fault) |-> ##[1:4] group_led) else $error("no led");
endmodule // aosd_core_properties

bind aosd_core aosd_core_properties aosd_core_properties_i (.clk, .reset, .output_code, .param_wr, .rec_rd,
  .rec_index, .open_circuit_pin, .aux_missing_pin, .diag_overflow, .comm_error, .module_fault, .drive,
  .rec_data, .rec_valid, .channel_led, .group_led);

`default_nettype wire

/* File: verif/aosd_host_model.sv */
// Backplane host model: parameter byte writes and diagnostic record byte reads.
`timescale 1ns/1ns
`default_nettype none

module aosd_host_model
  import aosd_pkg::*;
(
  input  wire logic                 clk,       // Module clock.
  output var aosd_pkg::aosd_param_wr_type pw,  // Parameter write.
  output var logic                  rec_rd,    // Read strobe.
  output var logic [4:0]            rec_index, // Read index.
  input  wire logic [7:0]           rec_data,  // Read byte.
  input  wire logic                 rec_valid  // Read answer.
);
  import aosd_pkg::*;
  initial begin
    pw = '0;
    rec_rd = 1'b0;
    rec_index = 5'h15;
  end

  // Idle lines show the inverse of the last value so stale data is never mistaken for fresh data.
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk);
    #2;
    pw = '{wr: 1'b1, index: i, data: d};
    @(posedge clk);
    #2;
    pw = '{wr: 1'b0, index: ~i, data: ~d};
  endtask

  // Set number, object index and per byte subindex all end in these byte reads; bytes 0..3 are the short record.
  task automatic rd(input logic [4:0] i, output logic [7:0] v);
    @(posedge clk);
    #2;
    rec_rd = 1'b1;
    rec_index = i;
    @(posedge clk);
    #2;
    rec_rd = 1'b0;
    rec_index = ~i;
    // The answer is launched by the taking edge, so it is only settled a little after it.
    v = rec_valid === 1'b1 ? rec_data : 8'hXX;
  endtask
endmodule // aosd_host_model

`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking testbench of the scaling and diagnostic block.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import aosd_pkg::*;
  logic clk, reset, aux, ovf, comm, fault, rv, rr;
  logic [NUM_CH-1:0][15:0] code;
  logic [NUM_CH-1:0] oc, led;
  logic gled;
  logic [7:0] v, rd8;
  logic [4:0] ri;
  logic [15:0] seed;
  logic [31:0] snap;
  aosd_param_wr_type pw;
  aosd_drive_type drive;
  int error_cnt, n_tests, cyc, t0;
  logic [7:0] fns [4] = '{8'h31, 8'h41, 8'h30, 8'h40};

  aosd_core aosd_core_i (.clk, .reset, .output_code(code), .param_wr(pw), .rec_rd(rr), .rec_index(ri),
    .open_circuit_pin(oc), .aux_missing_pin(aux), .diag_overflow(ovf), .comm_error(comm),
    .module_fault(fault), .drive, .rec_data(rd8), .rec_valid(rv), .channel_led(led), .group_led(gled));
  aosd_host_model aosd_host_model_i (.clk, .pw, .rec_rd(rr), .rec_index(ri), .rec_data(rd8), .rec_valid(rv));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("errors %0d of %0d compares", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= reset ? 0 : cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] exp_rec(logic [4:0] i);
    case (i)
      5'h01: return 8'h15;
      5'h04: return 8'h73;
      5'h05: return 8'h08;
      5'h06: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction

  // Microamps for a code, floored; slopes rounded up may land one microamp high.
  function automatic int exp_ua(logic [7:0] f, int c);
    int lo, hi, n, d;
    case (f)
      8'h31: begin lo = 0; hi = 32511; n = 20000; d = 27648; end
      8'h41: begin lo = 0; hi = 20480; n = 20000; d = 16384; end
      8'h30: begin lo = -6912; hi = 32511; n = 16000; d = 27648; end
      default: begin lo = -4096; hi = 20480; n = 16000; d = 16384; end
    endcase
    if (c < lo) c = lo;
    if (c > hi) c = hi;
    return (c - lo) * n / d;
  endfunction

  function automatic logic [15:0] near(logic [15:0] s, int e);
    return (int'(s) == e + 1) ? s : e[15:0];
  endfunction

  task automatic rchk(input logic [4:0] i, input logic [7:0] e);
    aosd_host_model_i.rd(i, v);
    chk(v, e);
  endtask

  initial begin
    code = '0; oc = '0; aux = 0; ovf = 0; comm = 0; fault = 0; reset = 1;
    error_cnt = 0; n_tests = 0; seed = 16'hFEB6;
    tick(10);
    reset = 0;
    tick(2);
    chk(drive.enable, 4'hF);
    for (int i = 0; i < 21; i++) rchk(i == 20 ? 5'h19 : 5'(i), exp_rec(i == 20 ? 5'h19 : 5'(i)));
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) aosd_host_model_i.wr(3'(2 + c), fns[f]);
      for (int n = 0; n < 24; n++) begin
        for (int c = 0; c < 4; c++) begin
          seed = lfsr(seed);
          code[c] = n == 0 ? 16'h8000 : n == 1 ? 16'h7FFF : n == 2 ? 16'hE500 : n == 3 ? 16'h4000 : seed;
        end
        tick(3);
        for (int c = 0; c < 4; c++) begin
          t0 = exp_ua(fns[f], $signed(code[c]));
          chk(drive.setpoint_ua[c], near(drive.setpoint_ua[c], t0));
        end
      end
      for (int c = 0; c < 4; c++) aosd_host_model_i.wr(3'(2 + c), 8'h31);
    end
    aosd_host_model_i.wr(3'h2, 8'hFF);
    tick(3);
    chk({drive.enable[0], drive.setpoint_ua[0]}, 17'h0);
    rchk(5'h00, 8'h00);
    t0 = cyc;
    aosd_host_model_i.wr(3'h4, 8'h55);
    tick(6);
    chk(drive.enable[2], 1'b0);
    rchk(5'h0A, 8'h01);
    rchk(5'h00, 8'h88);
    rchk(5'h07, 8'h04);
    chk({led, gled}, 5'h09);
    for (int b = 0; b < 4; b++) begin
      aosd_host_model_i.rd(5'(16 + b), v);
      snap[8*b+:8] = v;
    end
    chk(snap >= t0 / 10 && snap <= t0 / 10 + 2, 1);
    aosd_host_model_i.wr(3'h4, 8'h31);
    aosd_host_model_i.wr(3'h1, 8'hF2);
    oc = 4'hA;
    tick(8);
    rchk(5'h09, 8'h10);
    rchk(5'h0B, 8'h00);
    rchk(5'h00, 8'h0C);
    rchk(5'h07, 8'h02);
    oc = 0; aux = 1; fault = 1; ovf = 1;
    tick(8);
    rchk(5'h00, 8'h17);
    rchk(5'h03, 8'h08);
    ovf = 0; comm = 1;
    tick(3);
    rchk(5'h03, 8'h10);
    chk(gled, 1'b1);
    aux = 0; fault = 0; comm = 0;
    tick(8);
    rchk(5'h00, 8'h00);
    reset = 1;
    tick(2);
    reset = 0;
    tick(2);
    chk(drive.enable, 4'hF);
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
